// *** rtl/hvsw_pkg.sv ***
// Purpose: constants for the switch interface control block
// Assumes: 20 MHz system clock
// Notes: command word and register offsets are fixed here
package hvsw_pkg;
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned DEB_NS = 10000;
  localparam int unsigned DEB_CYC = (DEB_NS * CLK_KHZ) / 1000000;
  localparam int unsigned NCH = 8;
  localparam int unsigned NSINK = 3;
  localparam int unsigned NGATE = 3;
  localparam int unsigned AW = 4;
  localparam int unsigned DW = 16;
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CONFIG = 4'h8;
  localparam int unsigned B_PROG = 0;
  localparam int unsigned B_ADDR_LO = 1;
  localparam int unsigned B_ADDR_HI = 3;
  localparam int unsigned B_EN = 4;
  localparam int unsigned B_DIRECT = 5;
  localparam int unsigned B_SINK = 6;
  localparam int unsigned B_IRQEN = 7;
  localparam int unsigned B_SLOPE = 8;
  localparam int unsigned B_HALVE = 9;
  localparam int unsigned B_SRC_LO = 14;
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_CHANGE = 2'h1;
  localparam logic [1:0] SRC_THERMAL = 2'h2;
  // channel 1..8 -> gate pin index 0,1,2,2,1,1,0,0
  localparam logic [15:0] GATE_MAP = 16'h05A4;
endpackage : hvsw_pkg

// *** rtl/hvsw_ctrl.sv ***
// Purpose: control logic of eight current-source and switch-sense channels
// Assumes: pins are asynchronous to clk_i and pass two flops first
// Notes: analog levels, divider path and serial framing live elsewhere
// Summary of operation
// - channels 1-3 source when sink select 0, sink when 1; others source only
// - global halve bit: 0 full ratio, 1 halves output current
// - direct-on 1 keeps source on; 0 follows assigned gate pin
// - off when disabled or gated low; else drives high or low side
// - low-power allowed only while every enabled source is inhibited
// - gate rise on inhibited enabled channel in low power wakes device
// - gate 1 drives 1,7,8; gate 2 drives 2,5,6; gate 3 drives 3,4
// - slope disable default 0 smooth; 1 switches without transition
// - channel address is binary channel number minus one, bit 0 lsb
// - per-channel bits load only when program enable is 1
// - global slope bit updates only when program enable is 0
// - overtemperature shuts all sources down and raises an interrupt
// - shutdown keeps enable bits so sources resume after cooling
// - comparators off in sleep, else enabled with own source
// - comparators debounced; status 1 above threshold, 0 below
// - debounced state latched on falling gate pin or direct-on bit
// - latched change with irq enable set pulls interrupt low
// - detected state change acts as wake-up from low power
// - pending interrupt source cleared after status read
// - commands accepted only while chip select is low
`timescale 1ns/1ps
`default_nettype none
module hvsw_ctrl #(
  parameter int unsigned DEB_CYCLES = hvsw_pkg::DEB_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [hvsw_pkg::AW-1:0] addr_i,
  input wire logic [hvsw_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [hvsw_pkg::DW-1:0] rdata_o,
  input wire logic chip_select_n_i,
  input wire logic [hvsw_pkg::NGATE-1:0] gate_pin_i,
  input wire logic [hvsw_pkg::NCH-1:0] comp_raw_i,
  input wire logic overtemp_i,
  input wire logic sleep_i,
  input wire logic low_power_i,
  output logic [hvsw_pkg::NCH-1:0] src_high_o,
  output logic [hvsw_pkg::NSINK-1:0] src_low_o,
  output logic [hvsw_pkg::NCH-1:0] comp_en_o,
  output logic current_halve_o,
  output logic slope_disable_o,
  output logic low_power_ok_o,
  output logic wake_o,
  output logic irq_n_o
);
  import hvsw_pkg::*;

  // two-flop synchronisers, one pair per pin group; first stage read only by second
  // chip select resets to 0 so commands are accepted straight out of reset
  logic cs_s1_reg;
  logic cs_s2_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_s1_reg <= 1'b0;
      cs_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= chip_select_n_i;
      cs_s2_reg <= cs_s1_reg;
    end
  end
  wire cs_n = cs_s2_reg;

  logic hot_s1_reg;
  logic hot_s2_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hot_s1_reg <= 1'b0;
      hot_s2_reg <= 1'b0;
    end else begin
      hot_s1_reg <= overtemp_i;
      hot_s2_reg <= hot_s1_reg;
    end
  end
  wire hot = hot_s2_reg;

  logic slp_s1_reg;
  logic slp_s2_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slp_s1_reg <= 1'b0;
      slp_s2_reg <= 1'b0;
    end else begin
      slp_s1_reg <= sleep_i;
      slp_s2_reg <= slp_s1_reg;
    end
  end
  wire sleep = slp_s2_reg;

  logic lp_s1_reg;
  logic lp_s2_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lp_s1_reg <= 1'b0;
      lp_s2_reg <= 1'b0;
    end else begin
      lp_s1_reg <= low_power_i;
      lp_s2_reg <= lp_s1_reg;
    end
  end
  wire lp_mode = lp_s2_reg;

  // gate pins rest low, so a low reset value gives no false edge
  logic [NGATE-1:0] gate_s1_reg;
  logic [NGATE-1:0] gate_s2_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate_s1_reg <= '0;
      gate_s2_reg <= '0;
    end else begin
      gate_s1_reg <= gate_pin_i;
      gate_s2_reg <= gate_s1_reg;
    end
  end
  wire [NGATE-1:0] gate = gate_s2_reg;

  logic [NCH-1:0] comp_s1_reg;
  logic [NCH-1:0] comp_s2_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      comp_s1_reg <= '0;
      comp_s2_reg <= '0;
    end else begin
      comp_s1_reg <= comp_raw_i;
      comp_s2_reg <= comp_s1_reg;
    end
  end
  wire [NCH-1:0] comp_s = comp_s2_reg;

  // configuration state
  logic [NCH-1:0] en_reg;
  logic [NCH-1:0] direct_reg;
  logic [NCH-1:0] irqen_reg;
  logic [NSINK-1:0] sink_reg;
  logic slope_reg;
  logic halve_reg;
  logic [NGATE-1:0] gate_d_reg;
  logic [NCH-1:0] direct_d_reg;

  wire cmd_wr = wr_i && !cs_n && (addr_i == ADDR_CMD);
  wire prog = wdata_i[B_PROG];
  wire [2:0] sel = wdata_i[B_ADDR_HI:B_ADDR_LO];
  wire [NCH-1:0] sel_dec = NCH'(1) << sel;
  wire [NCH-1:0] ch_load = (cmd_wr && prog) ? sel_dec : '0;
  wire glob_load = cmd_wr && !prog;
  wire stat_rd = rd_i && (addr_i == ADDR_STATUS);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slope_reg <= 1'b0;
    end else if (glob_load) begin
      slope_reg <= wdata_i[B_SLOPE];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      halve_reg <= 1'b0;
    end else if (glob_load) begin
      halve_reg <= wdata_i[B_HALVE];
    end
  end

  // edge history for the off events; one cycle of latency is traded for clean edges
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate_d_reg <= '0;
    end else begin
      gate_d_reg <= gate;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      direct_d_reg <= '0;
    end else begin
      direct_d_reg <= direct_reg;
    end
  end
  wire [NGATE-1:0] gate_fall = gate_d_reg & ~gate;
  wire [NGATE-1:0] gate_rise = ~gate_d_reg & gate;

  // per-channel logic
  logic [NCH-1:0] deb_reg;
  logic [NCH-1:0] active;
  logic [NCH-1:0] off_evt;
  logic [NCH-1:0] wake_rise;
  logic [NCH-1:0] change;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      localparam int unsigned GI = 32'(GATE_MAP[2*g +: 2]);
      logic [15:0] cnt_reg;
      logic prev_reg;
      logic seeded_reg;

      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          en_reg[g] <= 1'b0;
          direct_reg[g] <= 1'b0;
          irqen_reg[g] <= 1'b0;
        end else if (ch_load[g]) begin
          en_reg[g] <= wdata_i[B_EN];
          direct_reg[g] <= wdata_i[B_DIRECT];
          irqen_reg[g] <= wdata_i[B_IRQEN];
        end
      end

      assign active[g] = en_reg[g] && (direct_reg[g] || gate[GI]);
      assign off_evt[g] = gate_fall[GI] || (direct_d_reg[g] && !direct_reg[g]);
      assign wake_rise[g] = en_reg[g] && !direct_reg[g] && gate_rise[GI];

      // debounce: input must hold a new level for the full count
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          cnt_reg <= '0;
          deb_reg[g] <= 1'b0;
        end else if (comp_s[g] == deb_reg[g]) begin
          cnt_reg <= '0;
        end else if (cnt_reg >= 16'(DEB_CYCLES - 1)) begin
          cnt_reg <= '0;
          deb_reg[g] <= comp_s[g];
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end

      // enabling re-arms seeding so the first sample raises nothing
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          prev_reg <= 1'b0;
          seeded_reg <= 1'b0;
        end else if (!en_reg[g]) begin
          seeded_reg <= 1'b0;
        end else if (off_evt[g]) begin
          prev_reg <= deb_reg[g];
          seeded_reg <= 1'b1;
        end
      end
      assign change[g] = en_reg[g] && off_evt[g] && seeded_reg && (prev_reg != deb_reg[g]);
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sink_reg <= '0;
    end else begin
      for (int i = 0; i < NSINK; i++) begin
        if (ch_load[i]) begin
          sink_reg[i] <= wdata_i[B_SINK];
        end
      end
    end
  end

  // drive enables; thermal stop gates outputs only, enables stay intact
  wire run = !hot && !sleep;
  wire [NCH-1:0] on = run ? active : '0;
  wire [NCH-1:0] sink_ext = {{(NCH-NSINK){1'b0}}, sink_reg};
  wire [NCH-1:0] high_next = on & ~sink_ext;
  wire [NSINK-1:0] low_next = on[NSINK-1:0] & sink_reg;
  wire [NCH-1:0] comp_next = sleep ? '0 : on;

  // interrupt sources, set wins over read clear
  logic chg_pend_reg;
  logic hot_pend_reg;
  logic hot_d_reg;
  wire chg_set = |(change & irqen_reg);
  wire hot_set = hot && !hot_d_reg;
  wire [1:0] src_code = hot_pend_reg ? SRC_THERMAL : (chg_pend_reg ? SRC_CHANGE : SRC_NONE);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hot_d_reg <= 1'b0;
    end else begin
      hot_d_reg <= hot;
    end
  end

  // an event in the read cycle is kept, so it is not lost to the read clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chg_pend_reg <= 1'b0;
    end else begin
      chg_pend_reg <= chg_set || (chg_pend_reg && !stat_rd);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hot_pend_reg <= 1'b0;
    end else begin
      hot_pend_reg <= hot_set || (hot_pend_reg && !stat_rd);
    end
  end

  wire [DW-1:0] stat_word = {src_code, {(DW-NCH-2){1'b0}}, deb_reg};
  wire [DW-1:0] cfg_word = {{(DW-NCH-2){1'b0}}, halve_reg, slope_reg, en_reg};
  wire [DW-1:0] rd_next = !rd_i ? '0 :
                          (addr_i == ADDR_STATUS) ? stat_word :
                          (addr_i == ADDR_CONFIG) ? cfg_word : '0;
  wire lp_ok = !(|active);
  wire wake_next = lp_mode && ((|wake_rise) || (|change));

  // every output straight from its own flop
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_high_o <= '0;
    end else begin
      src_high_o <= high_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_low_o <= '0;
    end else begin
      src_low_o <= low_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      comp_en_o <= '0;
    end else begin
      comp_en_o <= comp_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      current_halve_o <= 1'b0;
    end else begin
      current_halve_o <= halve_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slope_disable_o <= 1'b0;
    end else begin
      slope_disable_o <= slope_reg;
    end
  end

  // nothing is enabled in reset, so low power is allowed from the start
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_power_ok_o <= 1'b1;
    end else begin
      low_power_ok_o <= lp_ok;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= wake_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_n_o <= 1'b1;
    end else begin
      irq_n_o <= !(chg_pend_reg || hot_pend_reg);
    end
  end
endmodule : hvsw_ctrl
`default_nettype wire

// *** sim/hvsw_ctrl_checker.sv ***
// Purpose: port assertions for hvsw_ctrl
// Assumes: pins pass two sync flops before use
// Notes: waits of 4-5 samples cover sync plus output flop
`timescale 1ns/1ps
`default_nettype none
module hvsw_ctrl_checker #(
  parameter int unsigned DEB_CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic overtemp_i,
  input wire logic sleep_i,
  input wire logic low_power_i,
  input wire logic [7:0] src_high_o,
  input wire logic [2:0] src_low_o,
  input wire logic [7:0] comp_en_o,
  input wire logic current_halve_o,
  input wire logic slope_disable_o,
  input wire logic low_power_ok_o,
  input wire logic wake_o,
  input wire logic irq_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_hot_off: assert property (overtemp_i [*4] |-> src_high_o == '0 && src_low_o == '0)
    else $error("source on while hot");
  a_hot_irq: assert property ($rose(overtemp_i) ##1 (overtemp_i && !rd_i) [*5] |-> !irq_n_o)
    else $error("no irq on overtemp");
  a_lp_busy: assert property ((|src_high_o || |src_low_o) [*3] |-> !low_power_ok_o)
    else $error("low power allowed with source on");
  a_sleep_cmp: assert property (sleep_i [*4] |-> comp_en_o == '0)
    else $error("comparator on in sleep");
  a_sink_excl: assert property ((src_high_o[2:0] & src_low_o) == '0)
    else $error("high and low side together");
  a_wake_lp: assert property (!low_power_i [*5] |-> !wake_o)
    else $error("wake outside low power");
  a_cfg_write: assert property ($changed({current_halve_o, slope_disable_o}) |->
    $past(wr_i && !wdata_i[0], 1) || $past(wr_i && !wdata_i[0], 2))
    else $error("global bits moved without global write");
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside read slot");
  c_wake: cover property (wake_o);
  c_irq: cover property (!irq_n_o);
  c_sink: cover property (|src_low_o);
endmodule : hvsw_ctrl_checker
`default_nettype wire

// *** sim/hvsw_mcu_model.sv ***
// Purpose: far side: pwm master and switch loads
// Assumes: 400 ns pwm period
// Notes: pwm rests low between bursts
`timescale 1ns/1ps
`default_nettype none
module hvsw_mcu_model (
  input wire logic pwm_on_i,
  input wire logic [7:0] sw_i,
  output logic gate_o,
  output logic [7:0] comp_o
);
  initial gate_o = 1'b0;
  always #200 gate_o = pwm_on_i ? !gate_o : 1'b0;
  // closed switch lifts the pin over threshold
  assign comp_o = sw_i;
endmodule : hvsw_mcu_model
`default_nettype wire

// *** sim/tb_hvsw_ctrl.sv ***
// Purpose: self-checking bench for hvsw_ctrl
// Assumes: debounce shortened to 4 cycles
// Notes: reads queue expectations, a monitor compares
`timescale 1ns/1ps
`default_nettype none
module tb_hvsw_ctrl;
  import hvsw_pkg::*;
  logic clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, cs_n = 0, hot = 0, slp = 0, lp = 0;
  logic pwm = 0, rd_d = 0, pg, hv, sd, lpok, wk, irq_n;
  logic [3:0] addr = '0;
  logic [15:0] wdata = '0, rdata;
  logic [2:0] gate = '0, sl;
  logic [7:0] sw = '0, comp, sh, ce;
  logic [15:0] exq[$];
  int err_total = 0, n_tests = 0, wakes = 0;
  wire [15:0] outs = {4'h0, sl, lpok, sh};
  always #25 clk_i = !clk_i;
  hvsw_mcu_model u_hvsw_mcu_model (.pwm_on_i(pwm), .sw_i(sw), .gate_o(pg), .comp_o(comp));
  hvsw_ctrl #(.DEB_CYCLES(4)) u_hvsw_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .chip_select_n_i(cs_n),
    .gate_pin_i({gate[2:1], gate[0] | pg}), .comp_raw_i(comp), .overtemp_i(hot),
    .sleep_i(slp), .low_power_i(lp), .src_high_o(sh), .src_low_o(sl), .comp_en_o(ce),
    .current_halve_o(hv), .slope_disable_o(sd), .low_power_ok_o(lpok), .wake_o(wk),
    .irq_n_o(irq_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exq.push_back(e);
    @(posedge clk_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : rd
  function automatic logic [15:0] cmd(input int c, input logic [3:0] b);
    return {8'h00, b, c[2:0], 1'b1};
  endfunction : cmd
  task automatic wrap_up;
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) rd_d <= rd_i;
  always @(posedge clk_i) if (wk === 1'b1) wakes++;
  always @(negedge clk_i) if (rd_d) chk(rdata, exq.pop_front());
  initial begin
    #200_000;
    err_total++;
    wrap_up();
  end
  initial begin
    logic [15:0] r;
    logic [7:0] m [3];
    int w0;
    r = 16'($urandom(32'h9524_5387));
    r = 16'($urandom);
    m = '{8'hC1, 8'h32, 8'h0C};
    cyc(8);
    rst_b_i <= 1'b1;
    cyc(3);
    chk(outs, 16'h0100);
    rd(ADDR_CONFIG, 16'h0000);
    rd(4'hC, 16'h0000);
    for (int i = 0; i < 8; i++) wr(ADDR_CMD, cmd(i, 4'h3));
    for (int i = 0; i < 4; i++) wr(ADDR_CMD, cmd(i, 4'h7));
    cyc(3);
    chk(outs, 16'h0EF8);
    wr(ADDR_CMD, {6'h00, r[9:1], 1'b0});
    cyc(3);
    chk(outs, 16'h0EF8);
    chk({14'h0, hv, sd}, {14'h0, r[9:8]});
    wr(ADDR_CMD, {6'h00, ~r[9:8], 8'h7F});
    rd(ADDR_CONFIG, {6'h00, r[9:8], 8'hFF});
    cs_n <= 1'b1;
    cyc(3);
    wr(ADDR_CMD, cmd(0, 4'h0));
    cs_n <= 1'b0;
    cyc(3);
    chk(outs, 16'h0EF8);
    for (int i = 0; i < 8; i++) wr(ADDR_CMD, cmd(i, i == 0 ? 4'h9 : 4'h1));
    cyc(3);
    chk(outs, 16'h0100);
    for (int g = 0; g < 3; g++) begin
      gate <= 3'b001 << g;
      cyc(4);
      chk(outs, {8'h00, m[g]});
    end
    gate <= 3'b000;
    lp <= 1'b1;
    cyc(4);
    w0 = wakes;
    gate <= 3'b010;
    cyc(5);
    chk({15'h0, wakes > w0}, 16'h0001);
    gate <= 3'b000;
    cyc(4);
    chk({15'h0, irq_n}, 16'h0001);
    sw <= {r[7:1], 1'b1};
    cyc(12);
    w0 = wakes;
    pwm <= 1'b1;
    cyc(40);
    pwm <= 1'b0;
    cyc(4);
    chk({14'h0, irq_n, wakes > w0}, 16'h0001);
    rd(ADDR_STATUS, {2'b01, 6'h00, r[7:1], 1'b1});
    cyc(2);
    chk({15'h0, irq_n}, 16'h0001);
    lp <= 1'b0;
    gate <= 3'b111;
    cyc(4);
    chk({8'h00, ce}, 16'h00FF);
    hot <= 1'b1;
    cyc(6);
    chk({4'h0, sl, irq_n, sh}, 16'h0000);
    rd(ADDR_STATUS, {2'b10, 6'h00, r[7:1], 1'b1});
    hot <= 1'b0;
    cyc(5);
    chk({4'h0, sl, irq_n, sh}, 16'h01FF);
    slp <= 1'b1;
    cyc(5);
    chk({8'h00, ce}, 16'h0000);
    wrap_up();
  end
endmodule : tb_hvsw_ctrl
bind hvsw_ctrl hvsw_ctrl_checker #(.DEB_CYCLES(DEB_CYCLES)) u_chk (.*);
`default_nettype wire
